// *** hw/chlc_defs.svh ***
// Constants for the cell check, indicator and counter register bank.
// Assumes inclusion by the bank's modules only.
//
// Operation
// - Receive header check unless disabled, bit six.
// - Transmit header generated, fifth byte replaced unless disabled.
// - Marker width code gives 1, 2, 4, 8 cycles.
// - Queue empty status reads one, reset one.
// - Transmit activity bit shows cell sent.
// - Receive activity bit shows cell received.
// - Low readout gives selected counter bits 7-0.
// - High readout gives selected counter bits 15-8.
// - One-hot select chooses counter, bits 3..0.
// - Indicator pins low while cells pass.
// - Header mismatch sets sticky error flag.
`ifndef CHLC_DEFS_SVH
`define CHLC_DEFS_SVH
`define CHLC_ADDR_INT_STATUS 3'h1
`define CHLC_ADDR_CTRL 3'h3
`define CHLC_ADDR_CNT_LO 3'h4
`define CHLC_ADDR_CNT_HI 3'h5
`define CHLC_ADDR_SEL 3'h6
`define CHLC_BIT_RX_CHK_DIS 6
`define CHLC_BIT_TX_GEN_DIS 5
`define CHLC_BIT_WIDTH_HI 4
`define CHLC_BIT_WIDTH_LO 3
`define CHLC_BIT_QUEUE_EMPTY 2
`define CHLC_BIT_TX_ACT 1
`define CHLC_BIT_RX_ACT 0
`define CHLC_BIT_HEC_ERR_FLAG 5
`define CHLC_SEL_SYMBOL 3
`define CHLC_SEL_TX_CELL 2
`define CHLC_SEL_RX_CELL 1
`define CHLC_SEL_HEC_ERR 0
`define CHLC_HDR_BYTES 3'h4
`define CHLC_HEC_IDX 3'h4
`define CHLC_HEC_POLY 8'h07
`define CHLC_HEC_COSET 8'h55
`define CHLC_ACT_HOLD 16'h4e20
`endif

// *** hw/chlc_pkg.sv ***
// Types shared by the register bank and its counter memory.
// Assumes the constants header sits beside it.
package chlc_pkg;
    typedef logic [7:0] chlc_byte_t;
    typedef logic [15:0] chlc_count_t;
    typedef logic [1:0] chlc_width_t;
    typedef enum logic [1:0] {CHLC_CNT_HEC, CHLC_CNT_RX, CHLC_CNT_TX, CHLC_CNT_SYM} chlc_cnt_id_t;
endpackage : chlc_pkg

// *** hw/chlc_counters.sv ***
// Four 16-bit event counters with a registered readout of one of them.
// Assumes each event is a one-cycle strobe on the system clock.
`timescale 1ns/1ps
`include "chlc_defs.svh"
module chlc_counters (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] event_i,
    input wire chlc_pkg::chlc_cnt_id_t rd_sel_i,
    output chlc_pkg::chlc_count_t rd_data_o
);
    import chlc_pkg::*;
    chlc_count_t cnt_q [4];
    chlc_count_t cnt_d [4];
    chlc_count_t rd_q;
    chlc_count_t rd_d;

    // Each counter advances once per event and wraps at full scale.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cnt_d[i] = event_i[i] ? cnt_q[i] + 16'h0001 : cnt_q[i];
        end
        rd_d = cnt_q[rd_sel_i];
    end

    // Registers the counters and the readout word.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= 16'h0000;
            end
            rd_q <= 16'h0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
            rd_q <= rd_d;
        end
    end
    assign rd_data_o = rd_q;

    property p_wrap;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (event_i[0] && cnt_q[0] == 16'hffff) |=> cnt_q[0] == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Counter did not wrap.");
    property p_wrap_sym;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (event_i[`CHLC_SEL_SYMBOL] && cnt_q[`CHLC_SEL_SYMBOL] == 16'hffff) |=> cnt_q[`CHLC_SEL_SYMBOL] == 16'h0000;
    endproperty
    a_wrap_sym: assert property (p_wrap_sym) else $error("Symbol counter did not wrap.");
endmodule : chlc_counters

// *** hw/chlc_regs.sv ***
// Control and status bank: header check, marker width, activity pins, counter readout.
// Assumes a synchronous utility bus strobe pair and byte-wide cell streams with start markers.
`timescale 1ns/1ps
`include "chlc_defs.svh"
module chlc_regs (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    output chlc_pkg::chlc_byte_t bus_rdata_o,
    input wire logic rx_valid_i,
    input wire logic rx_start_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_symbol_err_i,
    input wire logic tx_valid_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic transmit_queue_empty_i,
    input wire logic int_status_clr_i,
    output logic tx_valid_o,
    output chlc_pkg::chlc_byte_t tx_byte_o,
    output logic receive_frame_marker_o,
    output logic hec_error_flag_o,
    output logic transmit_activity_indicator_n_o,
    output logic receive_activity_indicator_n_o
);
    import chlc_pkg::*;

    // Header check byte: CRC-8 over four header bytes, then the coset.
    function automatic chlc_byte_t crc_step(input chlc_byte_t crc, input chlc_byte_t data);
        chlc_byte_t c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `CHLC_HEC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_step

    logic rx_chk_dis_q, rx_chk_dis_d, tx_gen_dis_q, tx_gen_dis_d;
    chlc_width_t width_q, width_d;
    logic [3:0] sel_q, sel_d;
    chlc_byte_t rdata_q, rdata_d;
    logic [2:0] rx_idx_q, rx_idx_d, tx_idx_q, tx_idx_d;
    chlc_byte_t rx_crc_q, rx_crc_d, tx_crc_q, tx_crc_d;
    logic hec_flag_q, hec_flag_d, hec_evt;
    logic rx_cell_evt, tx_cell_evt;
    logic [3:0] mark_q, mark_d;
    logic mark_out_q, mark_out_d;
    logic [15:0] rx_hold_q, rx_hold_d, tx_hold_q, tx_hold_d;
    logic rx_led_q, rx_led_d, tx_led_q, tx_led_d;
    logic rx_act_q, rx_act_d, tx_act_q, tx_act_d;
    logic txv_q, txv_d;
    chlc_byte_t txb_q, txb_d;
    chlc_count_t cnt_word;
    chlc_cnt_id_t cnt_id;

    // Picks the counter named by the lowest set select bit.
    always_comb begin
        if (sel_q[`CHLC_SEL_HEC_ERR]) cnt_id = CHLC_CNT_HEC;
        else if (sel_q[`CHLC_SEL_RX_CELL]) cnt_id = CHLC_CNT_RX;
        else if (sel_q[`CHLC_SEL_TX_CELL]) cnt_id = CHLC_CNT_TX;
        else cnt_id = CHLC_CNT_SYM;
    end

    // Register writes and read data.
    always_comb begin
        rx_chk_dis_d = rx_chk_dis_q;
        tx_gen_dis_d = tx_gen_dis_q;
        width_d = width_q;
        sel_d = sel_q;
        if (bus_wr_i && bus_addr_i == `CHLC_ADDR_CTRL) begin
            rx_chk_dis_d = bus_wdata_i[`CHLC_BIT_RX_CHK_DIS];
            tx_gen_dis_d = bus_wdata_i[`CHLC_BIT_TX_GEN_DIS];
            width_d = bus_wdata_i[`CHLC_BIT_WIDTH_HI:`CHLC_BIT_WIDTH_LO];
        end
        if (bus_wr_i && bus_addr_i == `CHLC_ADDR_SEL) begin
            sel_d = bus_wdata_i[3:0];
        end
        rdata_d = rdata_q;
        if (bus_rd_i) begin
            rdata_d = 8'h00;
            unique case (bus_addr_i)
                `CHLC_ADDR_CTRL: begin
                    rdata_d[`CHLC_BIT_RX_CHK_DIS] = rx_chk_dis_q;
                    rdata_d[`CHLC_BIT_TX_GEN_DIS] = tx_gen_dis_q;
                    rdata_d[`CHLC_BIT_WIDTH_HI:`CHLC_BIT_WIDTH_LO] = width_q;
                    rdata_d[`CHLC_BIT_QUEUE_EMPTY] = transmit_queue_empty_i;
                    rdata_d[`CHLC_BIT_TX_ACT] = tx_act_q;
                    rdata_d[`CHLC_BIT_RX_ACT] = rx_act_q;
                end
                `CHLC_ADDR_INT_STATUS: rdata_d[`CHLC_BIT_HEC_ERR_FLAG] = hec_flag_q;
                `CHLC_ADDR_CNT_LO: rdata_d = cnt_word[7:0];
                `CHLC_ADDR_CNT_HI: rdata_d = cnt_word[15:8];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Receive header check and frame marker timing.
    always_comb begin
        rx_idx_d = rx_idx_q;
        rx_crc_d = rx_crc_q;
        hec_evt = 1'b0;
        rx_cell_evt = 1'b0;
        if (rx_valid_i) begin
            if (rx_start_i) begin
                rx_idx_d = 3'h1;
                rx_crc_d = crc_step(8'h00, rx_byte_i);
                rx_cell_evt = 1'b1;
            end else if (rx_idx_q < `CHLC_HDR_BYTES) begin
                rx_idx_d = rx_idx_q + 3'h1;
                rx_crc_d = crc_step(rx_crc_q, rx_byte_i);
            end else if (rx_idx_q == `CHLC_HEC_IDX) begin
                rx_idx_d = rx_idx_q + 3'h1;
                hec_evt = !rx_chk_dis_q && (rx_byte_i != (rx_crc_q ^ `CHLC_HEC_COSET));
            end
        end
        hec_flag_d = hec_evt ? 1'b1 : (int_status_clr_i ? 1'b0 : hec_flag_q);
        mark_d = (mark_q != 4'h0) ? mark_q - 4'h1 : 4'h0;
        if (rx_valid_i && rx_start_i) begin
            mark_d = 4'h1 << width_q;
        end
        mark_out_d = (mark_d != 4'h0);
    end

    // Transmit header generation and replacement of the fifth byte.
    always_comb begin
        tx_idx_d = tx_idx_q;
        tx_crc_d = tx_crc_q;
        tx_cell_evt = 1'b0;
        txv_d = tx_valid_i;
        txb_d = tx_byte_i;
        if (tx_valid_i) begin
            if (tx_start_i) begin
                tx_idx_d = 3'h1;
                tx_crc_d = crc_step(8'h00, tx_byte_i);
                tx_cell_evt = 1'b1;
            end else if (tx_idx_q < `CHLC_HDR_BYTES) begin
                tx_idx_d = tx_idx_q + 3'h1;
                tx_crc_d = crc_step(tx_crc_q, tx_byte_i);
            end else if (tx_idx_q == `CHLC_HEC_IDX) begin
                tx_idx_d = tx_idx_q + 3'h1;
                if (!tx_gen_dis_q) begin
                    txb_d = tx_crc_q ^ `CHLC_HEC_COSET;
                end
            end
        end
    end

    // Indicator pins stay lit for a hold time after each cell; activity status bits stay set until a control register read.
    always_comb begin
        rx_hold_d = rx_cell_evt ? `CHLC_ACT_HOLD : ((rx_hold_q != 16'h0) ? rx_hold_q - 16'h1 : 16'h0);
        tx_hold_d = tx_cell_evt ? `CHLC_ACT_HOLD : ((tx_hold_q != 16'h0) ? tx_hold_q - 16'h1 : 16'h0);
        rx_led_d = !(rx_hold_d != 16'h0);
        tx_led_d = !(tx_hold_d != 16'h0);
        rx_act_d = rx_cell_evt ? 1'b1 : rx_act_q;
        tx_act_d = tx_cell_evt ? 1'b1 : tx_act_q;
        if (bus_rd_i && bus_addr_i == `CHLC_ADDR_CTRL) begin
            rx_act_d = rx_cell_evt;
            tx_act_d = tx_cell_evt;
        end
    end

    // Registers all state of the bank.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_chk_dis_q <= 1'b0;
            tx_gen_dis_q <= 1'b0;
            width_q <= 2'h0;
            sel_q <= 4'h0;
            rdata_q <= 8'h00;
            rx_idx_q <= 3'h7;
            tx_idx_q <= 3'h7;
            rx_crc_q <= 8'h00;
            tx_crc_q <= 8'h00;
            hec_flag_q <= 1'b0;
            mark_q <= 4'h0;
            mark_out_q <= 1'b0;
            rx_hold_q <= 16'h0;
            tx_hold_q <= 16'h0;
            rx_led_q <= 1'b1;
            tx_led_q <= 1'b1;
            rx_act_q <= 1'b0;
            tx_act_q <= 1'b0;
            txv_q <= 1'b0;
            txb_q <= 8'h00;
        end else begin
            rx_chk_dis_q <= rx_chk_dis_d;
            tx_gen_dis_q <= tx_gen_dis_d;
            width_q <= width_d;
            sel_q <= sel_d;
            rdata_q <= rdata_d;
            rx_idx_q <= rx_idx_d;
            tx_idx_q <= tx_idx_d;
            rx_crc_q <= rx_crc_d;
            tx_crc_q <= tx_crc_d;
            hec_flag_q <= hec_flag_d;
            mark_q <= mark_d;
            mark_out_q <= mark_out_d;
            rx_hold_q <= rx_hold_d;
            tx_hold_q <= tx_hold_d;
            rx_led_q <= rx_led_d;
            tx_led_q <= tx_led_d;
            rx_act_q <= rx_act_d;
            tx_act_q <= tx_act_d;
            txv_q <= txv_d;
            txb_q <= txb_d;
        end
    end

    // Counter memory: events ordered by selector bit.
    chlc_counters u_counters (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .event_i({rx_valid_i && rx_symbol_err_i, tx_cell_evt, rx_cell_evt, hec_evt}),
        .rd_sel_i(cnt_id),
        .rd_data_o(cnt_word)
    );

    assign bus_rdata_o = rdata_q;
    assign tx_valid_o = txv_q;
    assign tx_byte_o = txb_q;
    assign receive_frame_marker_o = mark_out_q;
    assign hec_error_flag_o = hec_flag_q;
    assign transmit_activity_indicator_n_o = tx_led_q;
    assign receive_activity_indicator_n_o = rx_led_q;

    property p_mark_width;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rx_valid_i && rx_start_i && width_q == 2'h3 && !bus_wr_i) |=> receive_frame_marker_o [*8];
    endproperty
    a_mark_width: assert property (p_mark_width) else $error("Marker too short.");
    property p_mark_one;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rx_valid_i && rx_start_i && width_q == 2'h0) ##1 !(rx_valid_i && rx_start_i) |=> !receive_frame_marker_o;
    endproperty
    a_mark_one: assert property (p_mark_one) else $error("Marker too long.");
    property p_hec_sticky;
        @(posedge mclk_i) disable iff (!reset_n_i)
        hec_evt |=> hec_error_flag_o;
    endproperty
    a_hec_sticky: assert property (p_hec_sticky) else $error("Header error flag not set.");
    property p_rx_chk_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rx_chk_dis_q |-> !hec_evt;
    endproperty
    a_rx_chk_off: assert property (p_rx_chk_off) else $error("Check made while disabled.");
    property p_tx_pass;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (tx_valid_i && tx_gen_dis_q) |=> tx_byte_o == $past(tx_byte_i);
    endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("Byte altered while generation off.");
    property p_led_on;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rx_cell_evt |=> !receive_activity_indicator_n_o [*3];
    endproperty
    a_led_on: assert property (p_led_on) else $error("Receive indicator not low.");
    property p_tx_act;
        @(posedge mclk_i) disable iff (!reset_n_i)
        tx_cell_evt |=> tx_act_q;
    endproperty
    a_tx_act: assert property (p_tx_act) else $error("Transmit activity not shown.");
    property p_rx_act;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rx_cell_evt |=> rx_act_q;
    endproperty
    a_rx_act: assert property (p_rx_act) else $error("Receive activity not shown.");
    property p_queue;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_rd_i && bus_addr_i == `CHLC_ADDR_CTRL) |=> bus_rdata_o[`CHLC_BIT_QUEUE_EMPTY] == $past(transmit_queue_empty_i);
    endproperty
    a_queue: assert property (p_queue) else $error("Queue status wrong.");
    property p_lo;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_rd_i && bus_addr_i == `CHLC_ADDR_CNT_LO) |=> bus_rdata_o == $past(cnt_word[7:0]);
    endproperty
    a_lo: assert property (p_lo) else $error("Low counter byte wrong.");
    property p_hi;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_rd_i && bus_addr_i == `CHLC_ADDR_CNT_HI) |=> bus_rdata_o == $past(cnt_word[15:8]);
    endproperty
    a_hi: assert property (p_hi) else $error("High counter byte wrong.");
    property p_mark_two;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rx_valid_i && rx_start_i && width_q == 2'h1) |=> receive_frame_marker_o [*2];
    endproperty
    a_mark_two: assert property (p_mark_two) else $error("Two-cycle marker too short.");
    property p_led_idle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rx_hold_q == 16'h0 && !rx_cell_evt) |=> receive_activity_indicator_n_o;
    endproperty
    a_led_idle: assert property (p_led_idle) else $error("Receive indicator low while idle.");
    property p_tx_led_on;
        @(posedge mclk_i) disable iff (!reset_n_i)
        tx_cell_evt |=> !transmit_activity_indicator_n_o [*3];
    endproperty
    a_tx_led_on: assert property (p_tx_led_on) else $error("Transmit indicator not low.");
    property p_sel_write;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_wr_i && bus_addr_i == `CHLC_ADDR_SEL) |=> sel_q == $past(bus_wdata_i[3:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("Select write not taken.");
    property p_act_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (bus_rd_i && bus_addr_i == `CHLC_ADDR_CTRL && !rx_cell_evt) |=> !rx_act_q;
    endproperty
    a_act_clear: assert property (p_act_clear) else $error("Receive activity not cleared by read.");
    property p_hec_clr;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (int_status_clr_i && !hec_evt) |=> !hec_error_flag_o;
    endproperty
    a_hec_clr: assert property (p_hec_clr) else $error("Header error flag not cleared.");
endmodule : chlc_regs

// *** verification/chlc_atm_model.sv ***
// Observer model of the cell-layer device fed by the bank.
// Assumes one clock and the bank's transmit stream and marker outputs.
`timescale 1ns/1ps
module chlc_atm_model (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic marker_i,
    output logic [7:0] hec_seen_o,
    output logic [3:0] marker_len_o
);
    logic [2:0] idx_q;
    logic [3:0] run_q;
    // Captures the fifth byte of each cell and how many cycles each marker stays high.
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idx_q <= 3'h0;
            run_q <= 4'h0;
            hec_seen_o <= 8'h00;
            marker_len_o <= 4'h0;
        end else begin
            idx_q <= tx_valid_i ? idx_q + 3'h1 : 3'h0;
            if (tx_valid_i && idx_q == 3'h4) begin
                hec_seen_o <= tx_byte_i;
            end
            run_q <= marker_i ? run_q + 4'h1 : 4'h0;
            if (!marker_i && run_q != 4'h0) begin
                marker_len_o <= run_q;
            end
        end
    end
endmodule : chlc_atm_model

// *** verification/tb_top.sv ***
// Self-checking bench for the cell check, indicator and counter bank.
// Assumes the bank and the observer model compile beside it.
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [7:0] ctrl; logic bad; logic [3:0] len; logic flag;} chlc_row_t;
    chlc_row_t rows [4] = '{'{8'h00, 1'b1, 4'h1, 1'b1}, '{8'h08, 1'b0, 4'h2, 1'b0}, '{8'h30, 1'b1, 4'h4, 1'b1},
        '{8'h58, 1'b1, 4'h8, 1'b0}};
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [2:0] addr = 3'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rxv = 1'b0, rxs = 1'b0, sym = 1'b0, txv = 1'b0, txs = 1'b0, qe = 1'b1, iclr = 1'b0;
    logic [7:0] rxb = 8'h00, txb = 8'h00, hs, d, hb;
    logic [3:0] mlen;
    logic [31:0] hdr;
    chlc_pkg::chlc_byte_t rdata, tx_byte;
    logic tx_valid, marker, flag, tx_ind_n, rx_ind_n;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] cnt_exp [4] = '{8'h02, 8'h04, 8'h04, 8'h04};

    chlc_regs chlc_regs_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_addr_i(addr), .bus_wr_i(wr),
        .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .rx_valid_i(rxv), .rx_start_i(rxs),
        .rx_byte_i(rxb), .rx_symbol_err_i(sym), .tx_valid_i(txv), .tx_start_i(txs), .tx_byte_i(txb),
        .transmit_queue_empty_i(qe), .int_status_clr_i(iclr), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
        .receive_frame_marker_o(marker), .hec_error_flag_o(flag),
        .transmit_activity_indicator_n_o(tx_ind_n), .receive_activity_indicator_n_o(rx_ind_n));
    chlc_atm_model chlc_atm_model_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tx_valid_i(tx_valid),
        .tx_byte_i(tx_byte), .marker_i(marker), .hec_seen_o(hs), .marker_len_o(mlen));

    // Clock of 50 ns and a ceiling on the run length.
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 70000) begin
            errors++;
            end_of_test();
        end
    end

    // Header check: CRC-8 with polynomial 0x07 over four bytes, then xor 0x55.
    function automatic logic [7:0] hec_f(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
        return c ^ 8'h55;
    endfunction : hec_f

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_i) {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge mclk_i) wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk_i) {addr, rd} <= {a, 1'b1};
        @(posedge mclk_i) rd <= 1'b0;
        @(posedge mclk_i) #1 v = rdata;
    endtask : bus_rd

    // Sends one five-byte header on both streams, with a symbol error on the second byte.
    task automatic send(input logic [31:0] h, input logic [7:0] e);
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            {rxv, txv, rxs, txs, sym} <= {2'b11, {2{i == 0}}, i == 1};
            rxb <= (i < 4) ? h[31 - 8 * i -: 8] : e;
            txb <= (i < 4) ? h[31 - 8 * i -: 8] : e;
        end
        @(posedge mclk_i) {rxv, txv, rxs, txs, sym} <= 5'h00;
    endtask : send

    task automatic end_of_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        #1 check({6'h0, tx_ind_n, rx_ind_n}, 8'h03);
        bus_rd(3'h3, d);
        check(d, 8'h04);
        // Ordinary cases: marker widths, check and generate enables.
        for (int r = 0; r < 4; r++) begin
            @(posedge mclk_i) {iclr, qe} <= {1'b1, r[0]};
            @(posedge mclk_i) iclr <= 1'b0;
            bus_wr(3'h3, rows[r].ctrl);
            hdr = 32'h12345678 + r;
            hb = hec_f(hdr) ^ {7'h0, rows[r].bad};
            send(hdr, hb);
            repeat (12) @(posedge mclk_i);
            check({4'h0, mlen}, {4'h0, rows[r].len});
            check({7'h0, flag}, {7'h0, rows[r].flag});
            check(hs, rows[r].ctrl[5] ? hb : hec_f(hdr));
            check({6'h0, tx_ind_n, rx_ind_n}, 8'h00);
            bus_rd(3'h3, d);
            check(d, {1'b0, rows[r].ctrl[6:3], r[0], 2'b11});
            bus_rd(3'h3, d);
            check({6'h0, d[1:0]}, 8'h00);
            bus_rd(3'h1, d);
            check({7'h0, d[5]}, {7'h0, rows[r].flag});
        end
        // Each counter through the one-hot select.
        for (int k = 0; k < 4; k++) begin
            bus_wr(3'h6, 8'h01 << k);
            bus_rd(3'h4, d);
            check(d, cnt_exp[k]);
            bus_rd(3'h5, d);
            check(d, 8'h00);
        end
        bus_wr(3'h4, 8'hff);
        bus_rd(3'h4, d);
        check(d, 8'h04);
        bus_rd(3'h7, d);
        check(d, 8'h00);
        // A full-scale burst of symbol errors wraps the counter; the idle indicators return high.
        @(posedge mclk_i) {rxv, sym} <= 2'b11;
        repeat (65536) @(posedge mclk_i);
        {rxv, sym} <= 2'b00;
        bus_rd(3'h4, d);
        check(d, 8'h04);
        bus_rd(3'h5, d);
        check(d, 8'h00);
        check({6'h0, tx_ind_n, rx_ind_n}, 8'h03);
        @(posedge mclk_i) reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        bus_rd(3'h4, d);
        check(d, 8'h00);
        end_of_test();
    end
endmodule : tb_top
